// [hw/rtcs_pkg.sv]
// constants, field positions and types shared by the serial timekeeper design
// Function
// (RULE1) command top bit zero blocks all writes
// (RULE2) command bit six selects calendar or RAM
// (RULE3) command bits one to five give index
// (RULE4) command bit zero selects write or read
// (RULE5) command byte assembled least significant bit first
// (RULE6) session enable high enables the serial logic
// (RULE7) session enable low aborts, releases data pin
// (RULE8) sample on rising, launch on falling edge
// (RULE9) host keeps serial clock low at enable
// (RULE10) single write takes one byte, ignores rest
// (RULE11) write data received least significant bit first
// (RULE12) first read bit on next falling edge
// (RULE13) further clocks keep sending read bytes
// (RULE14) data pin released on every rising edge
// (RULE15) read data sent least significant bit first
// (RULE16) index thirty-one selects burst mode
// (RULE17) burst starts at location zero, then increments
// (RULE18) no storage calendar nine up, RAM 31
// (RULE19) clock burst commits only after eight bytes
// (RULE20) RAM burst commits each complete byte
// (RULE21) seven BCD time and calendar registers
// (RULE22) month end rollover with leap year February
// (RULE23) write lock blocks writes to other registers
// (RULE24) clock burst read served from snapshot copy
// (RULE25) seconds bit seven halts the clock
// (RULE26) divide 32768 Hz oscillator to one-second tick
package rtcs_pkg;
  localparam int unsigned OSC_HZ = 32768;
  localparam int TIME_REGS = 7;
  localparam int RAM_WORDS = 31;
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_SPACE_BIT = 6;
  localparam int CMD_IDX_LSB = 1;
  localparam int CMD_DIR_BIT = 0;
  localparam int HALT_BIT = 7;
  localparam int WLOCK_BIT = 7;
  localparam int H12_BIT = 7;
  localparam int PM_BIT = 5;
  localparam logic [4:0] IDX_SEC = 5'h00;
  localparam logic [4:0] IDX_CTRL = 5'h07;
  localparam logic [4:0] IDX_TRICKLE = 5'h08;
  localparam logic [4:0] IDX_BURST = 5'h1F;
  localparam logic [4:0] IDX_CLK_LAST = 5'h07;
  localparam logic [4:0] IDX_RAM_LAST = 5'h1E;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_WDAY_LAST = 8'h07;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  // reset time: year, weekday, month, date, hour, minute, second
  localparam logic [6:0][7:0] TM_RST = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_WDATA = 2'b01,
    PH_RDATA = 2'b11,
    PH_DONE = 2'b10
  } rtcs_phase_type;
endpackage

// [hw/rtcs_time_if.sv]
// carrier between register file and calendar counter
`timescale 1ns/1ns
interface rtcs_time_if;
  logic [6:0] ld;
  logic [6:0][7:0] ld_val;
  logic [6:0][7:0] tm;
  modport cal (input ld, input ld_val, output tm);
  modport regs (output ld, output ld_val, input tm);
endinterface

// [hw/rtcs_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ns
module rtcs_sync
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;

  // first stage is read by the second stage only
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= 1'b0;
      o_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// [hw/rtcs_cal.sv]
// BCD clock/calendar counter with oscillator divider
`timescale 1ns/1ns
module rtcs_cal
  import rtcs_pkg::*;
#(
  parameter int unsigned TICK_DIV = OSC_HZ
)
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_osc,
  rtcs_time_if.cal tif
);
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  logic osc_s;
  logic osc_prev_q;
  logic [DIV_W-1:0] div_q;
  logic tick;
  logic [6:0][7:0] tm_q;
  logic [6:0][7:0] nxt;
  logic halted;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  rtcs_sync u_osc_sync (.i_clk(i_mclk), .i_resetn(i_resetn), .i_d(i_osc), .o_q(osc_s));

  assign halted = tm_q[0][HALT_BIT]; // RULE25
  // halt also gates the tick itself, so a divide-by-one build stops as well
  assign tick = osc_s & ~osc_prev_q & (div_q == DIV_W'(TICK_DIV - 1)) & ~halted; // RULE25

  // divider counts oscillator rising edges; held at zero while halted
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      osc_prev_q <= 1'b0;
      div_q <= '0;
    end
    else
    begin
      osc_prev_q <= osc_s;
      if (halted) // RULE25
        div_q <= '0;
      else if (osc_s & ~osc_prev_q)
        div_q <= tick ? '0 : div_q + 1'b1; // RULE26
    end
  end

  // next time value, carry rippling seconds to years
  always_comb
  begin
    logic c;
    logic leap;
    logic [7:0] last;
    logic [7:0] inc;
    c = 1'b0;
    leap = 1'b0;
    last = BCD_31;
    inc = 8'h00;
    nxt = tm_q;
    if (tm_q[0][6:0] == BCD_59[6:0])
    begin
      nxt[0] = {tm_q[0][HALT_BIT], 7'h00};
      c = 1'b1;
    end
    else
    begin
      inc = bcd_inc({1'b0, tm_q[0][6:0]});
      nxt[0] = {tm_q[0][HALT_BIT], inc[6:0]};
    end
    if (c)
    begin
      c = (tm_q[1] == BCD_59);
      nxt[1] = c ? 8'h00 : bcd_inc(tm_q[1]);
    end
    if (c)
    begin
      if (tm_q[2][H12_BIT])
      begin
        // twelve-hour mode: 11 -> 12 flips meridian, 12 -> 01
        c = ({3'h0, tm_q[2][4:0]} == BCD_11) & tm_q[2][PM_BIT];
        if ({3'h0, tm_q[2][4:0]} == BCD_12)
          nxt[2] = {tm_q[2][7:5], BCD_ONE[4:0]};
        else if ({3'h0, tm_q[2][4:0]} == BCD_11)
          nxt[2] = {tm_q[2][7:6], ~tm_q[2][PM_BIT], BCD_12[4:0]};
        else
        begin
          inc = bcd_inc({3'h0, tm_q[2][4:0]});
          nxt[2] = {tm_q[2][7:5], inc[4:0]};
        end
      end
      else
      begin
        c = ({2'h0, tm_q[2][5:0]} == BCD_23);
        inc = bcd_inc({2'h0, tm_q[2][5:0]});
        nxt[2] = c ? 8'h00 : {2'h0, inc[5:0]};
      end
    end
    if (c)
      nxt[5] = (tm_q[5] == BCD_WDAY_LAST) ? BCD_ONE : bcd_inc(tm_q[5]);
    // leap years: BCD year divisible by four
    leap = tm_q[6][4] ? (tm_q[6][3:0] == 4'h2 || tm_q[6][3:0] == 4'h6)
                      : (tm_q[6][3:0] == 4'h0 || tm_q[6][3:0] == 4'h4 || tm_q[6][3:0] == 4'h8);
    if (tm_q[4] == MON_FEB)
      last = leap ? BCD_29 : BCD_28; // RULE22
    else if (tm_q[4] == MON_APR || tm_q[4] == MON_JUN || tm_q[4] == MON_SEP || tm_q[4] == MON_NOV)
      last = BCD_30; // RULE22
    if (c)
    begin
      c = (tm_q[3] == last);
      nxt[3] = c ? BCD_ONE : bcd_inc(tm_q[3]);
    end
    if (c)
    begin
      c = (tm_q[4] == BCD_12);
      nxt[4] = c ? BCD_ONE : bcd_inc(tm_q[4]);
    end
    if (c)
      nxt[6] = (tm_q[6] == BCD_99) ? 8'h00 : bcd_inc(tm_q[6]);
  end

  // per-register load wins over counting
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      tm_q <= TM_RST;
    else
      for (int k = 0; k < TIME_REGS; k++)
        if (tif.ld[k])
          tm_q[k] <= tif.ld_val[k];
        else if (tick && (tif.ld == 7'h00))
          tm_q[k] <= nxt[k]; // RULE21
  end

  assign tif.tm = tm_q;
endmodule

// [hw/rtcs_top.sv]
// three-wire serial access port with clock/calendar and scratchpad RAM
`timescale 1ns/1ns
module rtcs_top
  import rtcs_pkg::*;
#(
  parameter int unsigned TICK_DIV = OSC_HZ
)
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_ce,
  input wire logic i_dio,
  output logic o_dio,
  output logic o_dio_oe,
  input wire logic i_osc_input_pin,
  output logic o_halted,
  output logic o_write_lock
);
  // link domain (serial clock)
  logic link_rst_n;
  rtcs_phase_type phase_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shin_q;
  logic [7:0] shin_nxt;
  logic byte_end;
  logic space_q;
  logic burst_q;
  logic [4:0] idx_q;
  logic [4:0] idx_last;
  logic [4:0] idx_step;
  logic c_rd;
  logic c_wen;
  logic c_space;
  logic [4:0] c_idx;
  logic c_burst;
  logic req_fire;
  logic req_wr_d;
  logic [4:0] req_idx_d;
  logic req_first_d;
  logic req_space_d;
  logic req_burst_d;
  logic req_tgl_q;
  logic req_wr_q;
  logic [4:0] req_idx_q;
  logic req_first_q;
  logic req_space_q;
  logic req_burst_q;
  logic [7:0] req_data_q;
  logic [2:0] tx_cnt_q;
  logic [7:0] tx_sh_q;
  logic drive_q;
  // system domain
  logic req_tgl_s;
  logic req_seen_q;
  logic new_req;
  logic wr;
  logic wlock;
  logic clk_commit;
  logic [7:0] ctrl_q;
  logic [7:0] trickle_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_val;
  logic [7:0] ram_q [RAM_WORDS];
  logic [7:0] stage_q [TIME_REGS];
  logic [7:0] shadow_q [TIME_REGS];

  rtcs_time_if tif ();

  rtcs_cal #(.TICK_DIV(TICK_DIV)) u_cal
  (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_osc(i_osc_input_pin),
    .tif(tif.cal)
  );

  // serial logic only lives while a session is open; the low level clears it at once
  assign link_rst_n = i_resetn & i_ce; // RULE6 RULE7

  // incoming bits fill from the top so the first bit lands in bit zero
  assign shin_nxt = {i_dio, shin_q[7:1]}; // RULE5 RULE11
  assign byte_end = (bit_cnt_q == BIT_LAST);

  // command decode straight off the completing byte
  assign c_wen = shin_nxt[CMD_WEN_BIT]; // RULE1
  assign c_space = shin_nxt[CMD_SPACE_BIT]; // RULE2
  assign c_idx = shin_nxt[CMD_IDX_LSB +: 5]; // RULE3
  assign c_rd = shin_nxt[CMD_DIR_BIT]; // RULE4
  assign c_burst = (c_idx == IDX_BURST); // RULE16

  // read burst wraps at the end of the selected space; write burst stops there
  assign idx_last = space_q ? IDX_RAM_LAST : IDX_CLK_LAST;
  assign idx_step = (idx_q == idx_last) ? 5'h00 : idx_q + 5'h01;

  // rising edges: bit count, input shift and transfer phase
  always_ff @(posedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      phase_q <= PH_CMD;
      bit_cnt_q <= 3'h0;
      shin_q <= 8'h00;
      space_q <= 1'b0;
      burst_q <= 1'b0;
      idx_q <= 5'h00;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shin_q <= shin_nxt; // RULE8
      case (phase_q)
        PH_CMD:
        begin
          if (byte_end)
          begin
            space_q <= c_space;
            burst_q <= c_burst;
            idx_q <= c_burst ? IDX_SEC : c_idx; // RULE17
            if (c_rd)
              phase_q <= PH_RDATA;
            else if (c_wen)
              phase_q <= PH_WDATA;
            else
              phase_q <= PH_DONE; // RULE1
          end
        end
        PH_WDATA:
        begin
          if (byte_end)
          begin
            if (burst_q && idx_q != idx_last)
              idx_q <= idx_q + 5'h01; // RULE17
            else
              phase_q <= PH_DONE; // RULE10
          end
        end
        PH_RDATA:
        begin
          if (byte_end && burst_q)
            idx_q <= idx_step; // RULE13
        end
        default:
        begin
          // done: further clocks are ignored until the session closes
          phase_q <= PH_DONE; // RULE10
        end
      endcase
    end
  end

  // request to the system side at each byte boundary that needs one
  always_comb
  begin
    req_fire = 1'b0;
    req_wr_d = 1'b0;
    req_idx_d = idx_q;
    req_first_d = 1'b0;
    req_space_d = space_q;
    req_burst_d = burst_q;
    case (phase_q)
      PH_CMD:
      begin
        // a read fetches its first byte as soon as the command is in
        if (byte_end && c_rd)
        begin
          req_fire = 1'b1;
          req_idx_d = c_burst ? IDX_SEC : c_idx;
          req_first_d = c_burst; // RULE24
          req_space_d = c_space;
          req_burst_d = c_burst;
        end
      end
      PH_WDATA:
      begin
        if (byte_end)
        begin
          req_fire = 1'b1;
          req_wr_d = 1'b1;
        end
      end
      PH_RDATA:
      begin
        // single reads fetch the same location again
        if (byte_end)
        begin
          req_fire = 1'b1;
          req_idx_d = burst_q ? idx_step : idx_q; // RULE13
        end
      end
      default:
      begin
        req_fire = 1'b0;
      end
    endcase
  end

  // request word is held stable until the next toggle
  always_ff @(posedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      req_tgl_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_idx_q <= 5'h00;
      req_first_q <= 1'b0;
      req_space_q <= 1'b0;
      req_burst_q <= 1'b0;
      req_data_q <= 8'h00;
    end
    else if (req_fire)
    begin
      req_tgl_q <= ~req_tgl_q;
      req_wr_q <= req_wr_d;
      req_idx_q <= req_idx_d;
      req_first_q <= req_first_d;
      req_space_q <= req_space_d;
      req_burst_q <= req_burst_d;
      req_data_q <= shin_nxt; // RULE11
    end
  end

  // falling edges: launch read bits; rdata_q has been stable for half a serial period
  always_ff @(negedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      drive_q <= 1'b0;
      tx_cnt_q <= 3'h0;
      tx_sh_q <= 8'h00;
    end
    else if (phase_q == PH_RDATA)
    begin
      drive_q <= 1'b1; // RULE12
      tx_cnt_q <= tx_cnt_q + 3'h1;
      if (tx_cnt_q == 3'h0)
        tx_sh_q <= rdata_q; // RULE12 RULE15
      else
        tx_sh_q <= {1'b0, tx_sh_q[7:1]}; // RULE15 RULE8
    end
  end

  // pin is let go while the serial clock is high and whenever the session closes
  assign o_dio = tx_sh_q[0];
  assign o_dio_oe = drive_q & ~i_sclk & i_ce; // RULE14 RULE7

  // request toggle crosses by two flip-flops; the word is read once it is stable
  rtcs_sync u_req_sync (.i_clk(i_mclk), .i_resetn(i_resetn), .i_d(req_tgl_q), .o_q(req_tgl_s));

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      req_seen_q <= 1'b0;
    else
      req_seen_q <= req_tgl_s;
  end

  assign new_req = req_tgl_s ^ req_seen_q;
  assign wr = new_req & req_wr_q;
  assign wlock = ctrl_q[WLOCK_BIT];
  // the eighth byte of a clock burst releases all eight at once
  assign clk_commit = wr & ~req_space_q & req_burst_q & (req_idx_q == IDX_CLK_LAST) & ~wlock; // RULE19 RULE23

  // time register loads, single or committed burst
  genvar g;
  generate
    for (g = 0; g < TIME_REGS; g++)
    begin : g_ld
      assign tif.ld[g] = clk_commit | (wr & ~req_space_q & ~req_burst_q & ~wlock
                         & (req_idx_q == 5'(g))); // RULE23 RULE21
      assign tif.ld_val[g] = clk_commit ? stage_q[g] : req_data_q;
    end
  endgenerate

  // clock burst bytes wait here until the burst is complete
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int k = 0; k < TIME_REGS; k++)
        stage_q[k] <= 8'h00;
    end
    else if (wr && !req_space_q && req_burst_q && req_idx_q < IDX_CLK_LAST)
      stage_q[req_idx_q[2:0]] <= req_data_q; // RULE19
  end

  // control and trickle registers; only bit seven of control holds storage
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_q <= 8'h00;
      trickle_q <= 8'h00;
    end
    else
    begin
      if (clk_commit || (wr && !req_space_q && !req_burst_q && req_idx_q == IDX_CTRL))
        ctrl_q <= {req_data_q[WLOCK_BIT], 7'h00};
      if (wr && !req_space_q && !req_burst_q && req_idx_q == IDX_TRICKLE && !wlock)
        trickle_q <= req_data_q; // RULE23
    end
  end

  // scratchpad RAM; each complete byte goes in as it arrives
  always_ff @(posedge i_mclk)
  begin
    if (wr && req_space_q && req_idx_q <= IDX_RAM_LAST && !wlock)
      ram_q[req_idx_q] <= req_data_q; // RULE20 RULE18 RULE23
  end

  // snapshot taken at the start of a clock burst read, time keeps counting
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int k = 0; k < TIME_REGS; k++)
        shadow_q[k] <= 8'h00;
    end
    else if (new_req && !req_wr_q && req_first_q && !req_space_q)
    begin
      for (int k = 0; k < TIME_REGS; k++)
        shadow_q[k] <= tif.tm[k]; // RULE24
    end
  end

  // read data select; unbacked locations read as zero
  always_comb
  begin
    rd_val = 8'h00; // RULE18
    if (req_space_q)
    begin
      if (req_idx_q <= IDX_RAM_LAST)
        rd_val = ram_q[req_idx_q];
    end
    else if (req_idx_q < IDX_CTRL)
    begin
      if (req_burst_q && !req_first_q)
        rd_val = shadow_q[req_idx_q[2:0]]; // RULE24
      else
        rd_val = tif.tm[req_idx_q[2:0]];
    end
    else if (req_idx_q == IDX_CTRL)
      rd_val = ctrl_q;
    else if (req_idx_q == IDX_TRICKLE && !req_burst_q)
      rd_val = trickle_q;
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdata_q <= 8'h00;
    else if (new_req && !req_wr_q)
      rdata_q <= rd_val;
  end

  assign o_halted = tif.tm[0][HALT_BIT]; // RULE25
  assign o_write_lock = wlock;
endmodule

// [verification/rtcs_monitor.sv]
// pin-level checker for the serial timekeeper port
`timescale 1ns/1ns
module rtcs_monitor
  import rtcs_pkg::*;
#(
  parameter int unsigned TICK_DIV = OSC_HZ
)
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_ce,
  input wire logic i_dio,
  input wire logic o_dio,
  input wire logic o_dio_oe,
  input wire logic o_halted,
  input wire logic o_write_lock
);
  logic [9:0] cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] dat_q;
  logic byte_done;
  default clocking mc @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // serial rising edges in this session; saturates so long bursts never wrap
  always_ff @(posedge i_sclk or negedge i_ce)
  begin
    if (!i_ce)
      cnt_q <= 10'h000;
    else if (cnt_q != 10'h3FF)
      cnt_q <= cnt_q + 10'h001;
  end
  // command and first data byte as seen on the wire, lsb first
  always_ff @(posedge i_sclk or negedge i_ce)
  begin
    if (!i_ce)
    begin
      cmd_q <= 8'h00;
      dat_q <= 8'h00;
    end
    else if (cnt_q < 10'h008)
      cmd_q[cnt_q[2:0]] <= i_dio;
    else if (cnt_q < 10'h010)
      dat_q[cnt_q[2:0]] <= i_dio;
  end
  assign byte_done = (cnt_q == 10'h010);
  AST_OE_IDLE: assert property (!i_ce |-> !o_dio_oe)
    else $error("pin driven outside a session");
  AST_OE_RISE: assert property (i_sclk |-> !o_dio_oe)
    else $error("pin driven while serial clock high");
  AST_OE_CMD: assert property (cnt_q < 10'h008 |-> !o_dio_oe)
    else $error("pin driven during command byte");
  AST_OE_READ: assert property (i_ce && !i_sclk && cnt_q >= 10'h008 && cmd_q[0] |-> o_dio_oe)
    else $error("read data not driven");
  AST_OE_WRITE: assert property (i_ce && cnt_q >= 10'h008 && !cmd_q[0] |-> !o_dio_oe)
    else $error("pin driven during a write");
  AST_DIO_HOLD: assert property (i_ce && $past(i_ce) && !i_sclk && !$past(i_sclk) |-> $stable(o_dio))
    else $error("data changed away from falling edge");
  AST_HALT_SET: assert property ($rose(byte_done) && cmd_q == 8'h80 && !o_write_lock
    |-> ##[1:12] (o_halted == dat_q[7]))
    else $error("halt flag not taken from seconds write");
  AST_LOCK_SET: assert property ($rose(byte_done) && cmd_q == {1'b1, 1'b0, IDX_CTRL, 1'b0}
    |-> ##[1:12] (o_write_lock == dat_q[7]))
    else $error("lock flag not taken from control write");
  AST_LOCK_HOLD: assert property (o_write_lock && $past(o_write_lock) |-> $stable(o_halted))
    else $error("write went through while locked");
  AST_WEN_OFF: assert property (i_ce && cnt_q >= 10'h008 && !cmd_q[7] |-> $stable(o_halted) && $stable(o_write_lock))
    else $error("write done without enable bit");
  AST_BURST_SHORT: assert property (cmd_q == 8'hBE && cnt_q > 10'h008 && cnt_q < 10'h048 |-> $stable(o_halted))
    else $error("clock burst committed early");
endmodule
bind rtcs_top rtcs_monitor #(.TICK_DIV(TICK_DIV)) i_mon (.i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_sclk(i_sclk), .i_ce(i_ce), .i_dio(i_dio), .o_dio(o_dio), .o_dio_oe(o_dio_oe),
  .o_halted(o_halted), .o_write_lock(o_write_lock));

// [verification/rtcs_host.sv]
// host side model of the three-wire link
`timescale 1ns/1ns
module rtcs_host
(
  output logic o_ce,
  output logic o_sclk,
  output logic o_dio,
  output logic o_dio_en,
  input wire logic i_dio
);
  localparam int HALF = 80;
  // idle: session closed, serial clock parked
  initial
  begin
    o_ce = 1'b0;
    o_sclk = 1'b0;
    o_dio = 1'b0;
    o_dio_en = 1'b0;
  end
  // the clock is low before enable rises, else the first edge is misread
  task automatic open_s();
    #5;
    o_sclk = 1'b0;
    o_dio_en = 1'b1;
    #(HALF);
    o_ce = 1'b1;
    #(HALF);
  endtask
  task automatic close_s();
    // serial clock is already parked low by the last transfer
    #(HALF);
    o_ce = 1'b0;
    o_dio_en = 1'b0;
    #(3 * HALF);
  endtask
  // data changes with the falling edge and holds over the rising one
  task automatic put(input logic [7:0] b);
    o_dio_en = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      o_dio = b[i];
      #(HALF);
      o_sclk = 1'b1;
      #(HALF);
      o_sclk = 1'b0;
    end
  endtask
  // sample just before each rising edge, the device releases the pin on it
  task automatic get(output logic [7:0] b);
    o_dio_en = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      #(HALF - 2);
      b[i] = i_dio;
      #2;
      o_sclk = 1'b1;
      #(HALF);
      o_sclk = 1'b0;
    end
  endtask
endmodule

// [verification/rtcs_tb.sv]
// self-checking bench for the serial timekeeper port
`timescale 1ns/1ns
module testbench
  import rtcs_pkg::*;
;
  logic i_mclk;
  logic i_resetn;
  logic osc;
  logic ce;
  logic sclk;
  logic h_dio;
  logic h_en;
  logic dio_w;
  logic dut_dio;
  logic dut_oe;
  logic halted;
  logic wlock;
  int failures;
  int n_tests;
  int cyc = 0;
  logic [7:0] d;
  logic [39:0] cal [3];
  logic [7:0] ex [8];
  // released wire shows the inverse of the host's last driven level, never a kind value
  assign dio_w = dut_oe ? dut_dio : (h_en ? h_dio : ~h_dio);
  rtcs_host i_host (.o_ce(ce), .o_sclk(sclk), .o_dio(h_dio), .o_dio_en(h_en), .i_dio(dio_w));
  rtcs_top #(.TICK_DIV(4)) i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk), .i_ce(ce),
    .i_dio(dio_w), .o_dio(dut_dio), .o_dio_oe(dut_oe), .i_osc_input_pin(osc),
    .o_halted(halted), .o_write_lock(wlock));
  function automatic logic [7:0] cmd(input int we, input int ram, input logic [4:0] idx, input int rd);
    return {we[0], ram[0], idx, rd[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t: byte %h, expected %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t: flag %b, expected %b", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wr1(input logic [7:0] c, input logic [7:0] v);
    i_host.open_s();
    i_host.put(c);
    i_host.put(v);
    i_host.close_s();
  endtask
  task automatic rd1(input logic [7:0] c, output logic [7:0] v);
    i_host.open_s();
    i_host.put(c);
    i_host.get(v);
    i_host.close_s();
  endtask
  task automatic stop_test();
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // slow oscillator keeps a one-second tick longer than a single-byte access but shorter than a clock burst
  initial
  begin
    osc = 1'b0;
    forever #1000 osc = ~osc;
  end
  // hang guard, well above the expected run length
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    failures = 0;
    n_tests = 0;
    i_resetn = 1'b0;
    cal = '{40'h2302280301, 40'h2402280229, 40'h2304300501};
    repeat (20) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    chk_flag(wlock, 1'b0);
    rd1(cmd(1, 0, 5'h06, 1), d);
    chk(d, 8'h00);
    // scratchpad ends and middle; 0xDC and 0x37 expose bit order, 0x81 reads the same either way
    for (int k = 0; k < 3; k++)
      wr1(cmd(1, 1, 5'(k * 15), 0), 8'h81 + 8'(k * 91));
    for (int k = 0; k < 3; k++)
    begin
      rd1(cmd(1, 1, 5'(k * 15), 1), d);
      chk(d, 8'h81 + 8'(k * 91));
      wr1(cmd(1, 0, 5'(k * 10 + 9), 0), 8'hFF);
      rd1(cmd(1, 0, 5'(k * 10 + 9), 1), d);
      chk(d, 8'h00);
    end
    wr1(cmd(1, 0, IDX_TRICKLE, 0), 8'hA5);
    rd1(cmd(1, 0, IDX_TRICKLE, 1), d);
    chk(d, 8'hA5);
    i_host.open_s();
    i_host.put(cmd(1, 1, 5'h0F, 1));
    i_host.get(d);
    chk(d, 8'hDC);
    i_host.get(d);
    chk(d, 8'hDC);
    i_host.close_s();
    i_host.open_s();
    i_host.put(cmd(1, 1, 5'h05, 0));
    i_host.put(8'h11);
    i_host.put(8'h22);
    i_host.close_s();
    rd1(cmd(1, 1, 5'h05, 1), d);
    chk(d, 8'h11);
    wr1(cmd(0, 1, 5'h05, 0), 8'h99);
    rd1(cmd(1, 1, 5'h05, 1), d);
    chk(d, 8'h11);
    wr1(cmd(0, 0, IDX_SEC, 0), 8'h80);
    chk_flag(halted, 1'b0);
    wr1(cmd(1, 0, IDX_CTRL, 0), 8'hFF);
    chk_flag(wlock, 1'b1);
    rd1(cmd(1, 0, IDX_CTRL, 1), d);
    chk(d, 8'h80);
    wr1(cmd(1, 1, 5'h05, 0), 8'h77);
    wr1(cmd(1, 0, IDX_SEC, 0), 8'h80);
    chk_flag(halted, 1'b0);
    rd1(cmd(1, 1, 5'h05, 1), d);
    chk(d, 8'h11);
    wr1(cmd(1, 0, IDX_CTRL, 0), 8'h00);
    chk_flag(wlock, 1'b0);
    // short scratchpad burst still commits each whole byte
    i_host.open_s();
    i_host.put(cmd(1, 1, IDX_BURST, 0));
    for (int k = 0; k < 3; k++)
      i_host.put(8'hC1 + 8'(k));
    i_host.close_s();
    i_host.open_s();
    i_host.put(cmd(1, 1, IDX_BURST, 1));
    for (int k = 0; k < 3; k++)
    begin
      i_host.get(d);
      chk(d, 8'hC1 + 8'(k));
    end
    i_host.close_s();
    // month ends: plain year, leap year, thirty-day month; the last at 11 pm in twelve-hour mode
    for (int k = 0; k < 3; k++)
    begin
      ex = '{8'hD9, 8'h59, (k == 2) ? 8'hB1 : 8'h23, cal[k][23:16], cal[k][31:24], 8'h03, cal[k][39:32], 8'h00};
      i_host.open_s();
      i_host.put(cmd(1, 0, IDX_BURST, 0));
      for (int j = 0; j < 8; j++)
        i_host.put(ex[j]);
      i_host.close_s();
      chk_flag(halted, 1'b1);
      #12000;
      rd1(cmd(1, 0, IDX_SEC, 1), d);
      chk(d, 8'hD9);
      wr1(cmd(1, 0, IDX_SEC, 0), 8'h59);
      chk_flag(halted, 1'b0);
      #11000;
      ex = '{8'h00, 8'h00, (k == 2) ? 8'h92 : 8'h00, cal[k][7:0], cal[k][15:8], 8'h04, cal[k][39:32], 8'h00};
      i_host.open_s();
      i_host.put(cmd(1, 0, IDX_BURST, 1));
      for (int j = 0; j < 8; j++)
      begin
        i_host.get(d);
        chk(d, ex[j]);
      end
      i_host.close_s();
    end
    // clock burst cut short after two bytes must change nothing
    wr1(cmd(1, 0, IDX_SEC, 0), 8'h80);
    i_host.open_s();
    i_host.put(cmd(1, 0, IDX_BURST, 0));
    i_host.put(8'h00);
    i_host.put(8'h11);
    i_host.close_s();
    chk_flag(halted, 1'b1);
    rd1(cmd(1, 0, 5'h01, 1), d);
    chk(d, 8'h00);
    stop_test();
  end
endmodule
